// ==== swp_pkg.sv ====
package swp_pkg;
   localparam int CLK_MHZ        = 20;
   // slot timing in microseconds, standard and overdrive speed
   localparam int STD_SAMPLE_US  = 30;
   localparam int STD_PDH_US     = 30;
   localparam int STD_PDL_US     = 120;
   localparam int STD_RST_US     = 480;
   localparam int OD_SAMPLE_US   = 3;
   localparam int OD_PDH_US      = 3;
   localparam int OD_PDL_US      = 12;
   localparam int OD_RST_US      = 48;
   localparam int STD_RST_CYC    = STD_RST_US * CLK_MHZ;
   localparam int OD_RST_CYC     = OD_RST_US * CLK_MHZ;
   localparam logic [15:0] STD_SAMPLE_CYC = 16'(STD_SAMPLE_US * CLK_MHZ);
   localparam logic [15:0] STD_PDH_CYC    = 16'(STD_PDH_US * CLK_MHZ);
   localparam logic [15:0] STD_PDL_CYC    = 16'(STD_PDL_US * CLK_MHZ);
   localparam logic [15:0] OD_SAMPLE_CYC  = 16'(OD_SAMPLE_US * CLK_MHZ);
   localparam logic [15:0] OD_PDH_CYC     = 16'(OD_PDH_US * CLK_MHZ);
   localparam logic [15:0] OD_PDL_CYC     = 16'(OD_PDL_US * CLK_MHZ);

   localparam logic [7:0] NC_READ    = 8'h33;
   localparam logic [7:0] NC_MATCH   = 8'h55;
   localparam logic [7:0] NC_SKIP    = 8'hCC;
   localparam logic [7:0] NC_SEARCH  = 8'hF0;
   localparam logic [7:0] FN_READ    = 8'h69;
   localparam logic [7:0] FN_WRITE   = 8'h6C;

   localparam int          MEM_AW        = 9;
   localparam logic [15:0] MEM_LAST      = 16'h01FF;
   localparam logic [15:0] FUNC_CMD_ADDR = 16'h0060;
   localparam logic [15:0] SEC_CMD_ADDR  = 16'h00BB;
   localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
   localparam int          AREA_LSB      = 5;

   localparam logic [15:0] CMD_MAC_ONES    = 16'h3600;
   localparam logic [15:0] CMD_MAC_ADDR    = 16'h3500;
   localparam logic [15:0] CMD_SECRET_ONES = 16'h3000;
   localparam logic [15:0] CMD_SECRET_ADDR = 16'h3300;
   localparam logic [15:0] CMD_CLR_SECRET  = 16'h5A00;
   localparam logic [15:0] CMD_LOCK_SECRET = 16'h6000;
   localparam logic [15:0] CMD_COPY_NV     = 16'hE904;
   localparam logic [15:0] CMD_RECALL_NV   = 16'hE001;
   localparam logic [7:0]  CMD_HIST_HI     = 8'hE2;
   localparam logic [7:0]  CMD_LOCK_HI     = 8'h6A;
   localparam logic [15:0] CMD_HW_RESET    = 16'h000F;
   localparam logic [15:0] CMD_GAUGE_RST   = 16'h0001;

   // arbitrary identity values
   localparam logic [7:0]  FAMILY_CODE = 8'h5A;
   localparam logic [47:0] SERIAL_NUM  = 48'h0123456789AB;

   // x^8+x^5+x^4+1, lsb first
   function automatic logic [7:0] swp_crc8(input logic [55:0] d);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 0; i < 56; i++)
      begin
         fb = c[0] ^ d[i];
         c  = c >> 1;
         if (fb)
            c = c ^ 8'h8C;
      end
      return c;
   endfunction : swp_crc8

   localparam logic [63:0] NET_ADDR =
      {swp_crc8({SERIAL_NUM, FAMILY_CODE}), SERIAL_NUM, FAMILY_CODE};

   typedef struct packed {
      logic       mac_ones;
      logic       mac_addr;
      logic       secret_ones;
      logic       secret_addr;
      logic       clear_secret;
      logic       copy_nv;
      logic       recall_nv;
      logic       recall_hist;
      logic       hw_reset;
      logic       gauge_restart;
      logic [7:0] arg;
   } swp_act_s;

   typedef enum logic [2:0] {PH_IDLE, PH_SLOT, PH_RST, PH_WAIT, PH_PRES} swp_phase_e;
   typedef enum logic [3:0] {ST_IDLE, ST_NETCMD, ST_READADDR, ST_MATCH, ST_SEARCH,
                             ST_FUNC, ST_ADDR, ST_RDATA, ST_WDATA} swp_state_e;
endpackage : swp_pkg

// ==== swp_mem.sv ====
`timescale 1ns/10ps
module swp_mem #(
   parameter int AW = 9,
   parameter int DW = 8
) (
   input  wire logic          core_clk,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge core_clk)
   begin
      if (we)
         mem[addr] <= wdata;
      rdata <= mem[addr];
   end
endmodule : swp_mem

// ==== swp_port.sv ====
`timescale 1ns/10ps
module swp_port
   import swp_pkg::*;
#(
   parameter int RST_STD_CYC = STD_RST_CYC,
   parameter int RST_OD_CYC  = OD_RST_CYC
) (
   input  wire logic        core_clk,
   input  wire logic        reset,
   input  wire logic        line_in,
   output logic             line_out,
   output logic             line_oe,
   input  wire logic        speed_select_pin,
   output swp_act_s         act,
   output logic             secret_locked,
   output logic [15:0]      area_locked,
   output logic [15:0]      function_command,
   output logic [15:0]      secondary_command
);
   logic             ln_q1;
   logic             ln_q2;
   logic             ln_prev;
   logic             spd_q1;
   logic             spd_q2;
   swp_phase_e       ph;
   swp_state_e       state;
   logic [15:0]      tcnt;
   logic [15:0]      low_cnt;
   logic [15:0]      samp_cyc;
   logic [15:0]      pdh_cyc;
   logic [15:0]      pdl_cyc;
   logic [15:0]      rst_cyc;
   logic             fall;
   logic             rise;
   logic             rst_evt;
   logic             pres_done;
   logic             bit_done;
   logic             bit_val;
   logic             tx_bit;
   logic             dev_tx;
   logic             own_bit;
   logic [5:0]       bitcnt;
   logic [1:0]       step;
   logic             mism;
   logic [15:0]      shreg;
   logic [15:0]      ptr;
   logic [7:0]       rx_byte;
   logic [7:0]       rd_q;
   logic             mem_we;
   logic [7:0]       cmd_lo;
   logic [7:0]       sec_lo;
   logic             cmd_fire;
   logic             sec_fire;

   // pin synchronisers
   always_ff @(posedge core_clk)
   begin
      ln_q1   <= line_in;
      ln_q2   <= ln_q1;
      ln_prev <= ln_q2;
      spd_q1  <= speed_select_pin;
      spd_q2  <= spd_q1;
   end

   assign fall = ln_prev & ~ln_q2;
   assign rise = ~ln_prev & ln_q2;

   // speed pin high selects overdrive
   assign samp_cyc = spd_q2 ? OD_SAMPLE_CYC : STD_SAMPLE_CYC;
   assign pdh_cyc  = spd_q2 ? OD_PDH_CYC : STD_PDH_CYC;
   assign pdl_cyc  = spd_q2 ? OD_PDL_CYC : STD_PDL_CYC;
   assign rst_cyc  = spd_q2 ? 16'(RST_OD_CYC) : 16'(RST_STD_CYC);

   always_ff @(posedge core_clk)
   begin
      if (reset || ln_q2)
         low_cnt <= 16'h0000;
      else if (low_cnt != 16'hFFFF)
         low_cnt <= 16'(low_cnt + 16'h0001);
   end

   assign rst_evt = !ln_q2 && low_cnt == rst_cyc && ph != PH_PRES && ph != PH_RST;
   assign pres_done = ph == PH_PRES && tcnt == 16'(pdl_cyc - 16'h0001);
   assign bit_done = ph == PH_SLOT && tcnt == samp_cyc;
   assign bit_val  = ln_q2;

   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         ph   <= PH_IDLE;
         tcnt <= 16'h0000;
      end
      else if (rst_evt)
         ph <= PH_RST;
      else
      begin
         unique case (ph)
            PH_IDLE:
            begin
               tcnt <= 16'h0000;
               if (fall)
                  ph <= PH_SLOT;
            end
            PH_SLOT:
            begin
               if (tcnt != 16'hFFFF)
                  tcnt <= 16'(tcnt + 16'h0001);
               if (tcnt > samp_cyc && ln_q2)
                  ph <= PH_IDLE;
            end
            PH_RST:
            begin
               tcnt <= 16'h0000;
               if (rise)
                  ph <= PH_WAIT;
            end
            PH_WAIT:
            begin
               tcnt <= 16'(tcnt + 16'h0001);
               if (tcnt == 16'(pdh_cyc - 16'h0001))
               begin
                  ph   <= PH_PRES;
                  tcnt <= 16'h0000;
               end
            end
            PH_PRES:
            begin
               tcnt <= 16'(tcnt + 16'h0001);
               if (pres_done)
                  ph <= PH_IDLE;
            end
         endcase
      end
   end

   assign own_bit = NET_ADDR[bitcnt];
   assign dev_tx  = state == ST_READADDR || state == ST_RDATA ||
                    (state == ST_SEARCH && step != 2'd2);

   always_comb
   begin
      unique case (state)
         ST_READADDR: tx_bit = own_bit;
         ST_SEARCH:   tx_bit = (step == 2'd0) ? own_bit : ~own_bit;
         ST_RDATA:    tx_bit = rd_q[bitcnt[2:0]];
         default:     tx_bit = 1'b1;
      endcase
   end

   // open drain: only ever pull low; slot bits freed at the sample point, presence at pres_done
   assign line_out = 1'b0;
   assign line_oe  = ph == PH_PRES ||
                     (ph == PH_SLOT && dev_tx && !tx_bit && tcnt < samp_cyc);

   assign rx_byte = {bit_val, shreg[15:9]};

   always_ff @(posedge core_clk)
   begin
      if (reset || rst_evt)
      begin
         state  <= ST_IDLE;
         bitcnt <= 6'd0;
         step   <= 2'd0;
         mism   <= 1'b0;
         shreg  <= 16'h0000;
         ptr    <= 16'h0000;
      end
      else if (pres_done)
      begin
         state  <= ST_NETCMD;
         bitcnt <= 6'd0;
      end
      else if (bit_done)
      begin
         shreg  <= {bit_val, shreg[15:1]};
         bitcnt <= 6'(bitcnt + 6'd1);
         unique case (state)
            ST_IDLE: bitcnt <= 6'd0;
            ST_NETCMD:
               if (bitcnt == 6'd7)
               begin
                  bitcnt <= 6'd0;
                  mism   <= 1'b0;
                  step   <= 2'd0;
                  unique case (rx_byte)
                     NC_READ:   state <= ST_READADDR;
                     NC_MATCH:  state <= ST_MATCH;
                     NC_SKIP:   state <= ST_FUNC;
                     NC_SEARCH: state <= ST_SEARCH;
                     default:   state <= ST_IDLE;
                  endcase
               end
            ST_READADDR:
               if (bitcnt == 6'd63)
                  state <= ST_FUNC;
            ST_MATCH:
            begin
               mism <= mism | (bit_val != own_bit);
               if (bitcnt == 6'd63)
                  state <= (mism || bit_val != own_bit) ? ST_IDLE : ST_FUNC;
            end
            ST_SEARCH:
            begin
               bitcnt <= bitcnt;
               step   <= 2'(step + 2'd1);
               if (step == 2'd2)
               begin
                  step   <= 2'd0;
                  bitcnt <= 6'(bitcnt + 6'd1);
                  if (bit_val != own_bit)
                     state <= ST_IDLE;
                  else if (bitcnt == 6'd63)
                     state <= ST_FUNC;
               end
            end
            ST_FUNC:
               if (bitcnt == 6'd7)
               begin
                  bitcnt <= 6'd0;
                  mism   <= rx_byte == FN_WRITE;
                  state  <= (rx_byte == FN_READ || rx_byte == FN_WRITE) ? ST_ADDR : ST_IDLE;
               end
            ST_ADDR:
               if (bitcnt == 6'd15)
               begin
                  bitcnt <= 6'd0;
                  ptr    <= {bit_val, shreg[15:1]};
                  state  <= mism ? ST_WDATA : ST_RDATA;
               end
            ST_RDATA, ST_WDATA:
               if (bitcnt[2:0] == 3'd7)
               begin
                  bitcnt <= 6'd0;
                  ptr    <= 16'(ptr + 16'h0001);
               end
         endcase
      end
   end

   // whole byte only, inside the map, area not locked
   assign mem_we = bit_done && state == ST_WDATA && bitcnt[2:0] == 3'd7 &&
                   ptr <= MEM_LAST && !area_locked[ptr[8:AREA_LSB]];

   swp_mem #(
      .AW (MEM_AW),
      .DW (8)
   ) u_shadow (
      .core_clk (core_clk),
      .we       (mem_we),
      .addr     (ptr[MEM_AW-1:0]),
      .wdata    (rx_byte),
      .rdata    (rd_q)
   );

   // command words: low byte at the register address, high byte next, high fires
   always_ff @(posedge core_clk)
   begin
      cmd_fire <= 1'b0;
      sec_fire <= 1'b0;
      if (reset)
      begin
         function_command  <= CMD_RESET_VAL;
         secondary_command <= CMD_RESET_VAL;
         cmd_lo            <= 8'h00;
         sec_lo            <= 8'h00;
      end
      else if (mem_we)
      begin
         if (ptr == FUNC_CMD_ADDR)
            cmd_lo <= rx_byte;
         if (ptr == 16'(FUNC_CMD_ADDR + 16'h0001))
         begin
            function_command <= {rx_byte, cmd_lo};
            cmd_fire         <= 1'b1;
         end
         if (ptr == SEC_CMD_ADDR)
            sec_lo <= rx_byte;
         if (ptr == 16'(SEC_CMD_ADDR + 16'h0001))
         begin
            secondary_command <= {rx_byte, sec_lo};
            sec_fire          <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      act <= '0;
      if (reset)
      begin
         secret_locked <= 1'b0;
         area_locked   <= 16'h0000;
      end
      else if (cmd_fire)
      begin
         act.arg         <= function_command[7:0];
         act.mac_ones    <= function_command == CMD_MAC_ONES;
         act.mac_addr    <= function_command == CMD_MAC_ADDR;
         act.secret_ones <= function_command == CMD_SECRET_ONES && !secret_locked;
         act.secret_addr <= function_command == CMD_SECRET_ADDR && !secret_locked;
         act.clear_secret <= function_command == CMD_CLR_SECRET && !secret_locked;
         act.copy_nv     <= function_command == CMD_COPY_NV;
         act.recall_nv   <= function_command == CMD_RECALL_NV ||
                            function_command == CMD_HW_RESET;
         act.recall_hist <= function_command[15:8] == CMD_HIST_HI;
         act.hw_reset    <= function_command == CMD_HW_RESET;
         if (function_command == CMD_LOCK_SECRET)
            secret_locked <= 1'b1;
         if (function_command[15:8] == CMD_LOCK_HI)
            area_locked[function_command[3:0]] <= 1'b1;
      end
      else if (sec_fire)
      begin
         act.arg           <= secondary_command[7:0];
         act.gauge_restart <= secondary_command == CMD_GAUGE_RST;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   sequence s_wait_end;
      ph == PH_WAIT && tcnt == 16'(pdh_cyc - 16'h0001);
   endsequence

   property p_pres_start;
      s_wait_end |=> ph == PH_PRES && line_oe;
   endproperty
   a_pres_start: assert property (p_pres_start) else $error("presence not driven");

   property p_wait_quiet;
      ph == PH_WAIT |-> !line_oe;
   endproperty
   a_wait_quiet: assert property (p_wait_quiet) else $error("drive during wait");

   property p_rst_detect;
      rst_evt |=> ph == PH_RST && state == ST_IDLE;
   endproperty
   a_rst_detect: assert property (p_rst_detect) else $error("reset not taken");

   property p_one_sample;
      bit_done |=> !bit_done [*2];
   endproperty
   a_one_sample: assert property (p_one_sample) else $error("double sample");

   property p_tx_free;
      ph == PH_SLOT && tcnt >= samp_cyc |-> !line_oe;
   endproperty
   a_tx_free: assert property (p_tx_free) else $error("line held after sample");

   property p_search_drop;
      bit_done && state == ST_SEARCH && step == 2'd2 && bit_val != own_bit
         |=> state == ST_IDLE;
   endproperty
   a_search_drop: assert property (p_search_drop) else $error("search loser kept");

   property p_rd_inc;
      bit_done && state == ST_RDATA && bitcnt[2:0] == 3'd7
         |=> ptr == 16'($past(ptr) + 16'h0001);
   endproperty
   a_rd_inc: assert property (p_rd_inc) else $error("read address not advanced");

   property p_wr_guard;
      mem_we |-> ptr <= MEM_LAST && !area_locked[ptr[8:AREA_LSB]];
   endproperty
   a_wr_guard: assert property (p_wr_guard) else $error("forbidden write");

   property p_copy;
      cmd_fire && function_command == CMD_COPY_NV |=> act.copy_nv;
   endproperty
   a_copy: assert property (p_copy) else $error("copy not issued");

   property p_lock_keep;
      $past(secret_locked) |-> secret_locked && !act.clear_secret;
   endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("secret lock lost");
endmodule : swp_port

// ==== swp_host_model.sv ====
`timescale 1ns/10ps
module swp_host_model #(
   parameter int SLOT  = 66,
   parameter int LOW0  = 65,
   parameter int LOW1  = 20,
   parameter int RSAMP = 30,
   parameter int REC   = 20
) (
   input  wire logic core_clk,
   input  wire logic line,
   output logic      host_low
);
   initial host_low = 1'b0;

   // one slot; a write 1 doubles as a read slot
   task automatic slot(input logic b, output logic r);
      r = 1'b0;
      host_low <= 1'b1;
      for (int i = 0; i < SLOT; i++)
      begin
         @(posedge core_clk);
         if (i == (b ? LOW1 : LOW0))
            host_low <= 1'b0;
         if (i == RSAMP)
         begin
            @(negedge core_clk);
            r = line;
         end
      end
      repeat (REC) @(posedge core_clk);
   endtask : slot

   task automatic send(input logic [7:0] d, input int nbits);
      logic r;
      for (int i = 0; i < nbits; i++)
         slot(d[i], r);
   endtask : send

   task automatic recv(output logic [7:0] d);
      for (int i = 0; i < 8; i++)
         slot(1'b1, d[i]);
   endtask : recv

   // reset pulse, then time the presence answer in cycles
   task automatic bus_reset(input int rstl, output int t_wait, output int t_low);
      host_low <= 1'b1;
      repeat (rstl) @(posedge core_clk);
      host_low <= 1'b0;
      t_wait = 0;
      t_low = 0;
      do
      begin
         @(negedge core_clk);
         t_wait++;
      end
      while (line === 1'b1 && t_wait < 5000);
      while (line === 1'b0 && t_low < 5000)
      begin
         @(negedge core_clk);
         t_low++;
      end
      repeat (REC + 2) @(posedge core_clk);
   endtask : bus_reset
endmodule : swp_host_model

// ==== tb_single_wire_slave_port.sv ====
`timescale 1ns/10ps
module tb_single_wire_slave_port
   import swp_pkg::*;
;
   localparam int RST_STD = 1000;
   localparam int RST_OD  = 100;
   localparam logic [15:0] CODES [13] = '{CMD_MAC_ONES, CMD_MAC_ADDR, CMD_SECRET_ONES,
      CMD_SECRET_ADDR, CMD_CLR_SECRET, CMD_COPY_NV, CMD_RECALL_NV, 16'hE227, CMD_HW_RESET,
      CMD_GAUGE_RST, 16'h6A0F, CMD_LOCK_SECRET, CMD_CLR_SECRET};
   localparam logic [9:0] MASKS [13] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020,
      10'h010, 10'h008, 10'h004, 10'h00A, 10'h001, 10'h000, 10'h000, 10'h000};
   logic        core_clk;
   logic        reset;
   logic        speed_select_pin;
   logic        line_out;
   logic        line_oe;
   logic        host_low;
   logic        bus_line;
   swp_act_s    act;
   logic        secret_locked;
   logic [15:0] area_locked;
   logic [15:0] function_command;
   logic [15:0] secondary_command;
   logic [9:0]  seen;
   logic [7:0]  seen_arg;
   logic        clr_seen;
   int          n_fail;
   int          n_compared;
   logic [7:0]  mem_model [int];
   logic [15:0] lock_model;
   logic [31:0] rnd;
   logic [63:0] exp_addr;

   assign bus_line = (line_oe ? line_out : 1'b1) & ~host_low;

   swp_port #(.RST_STD_CYC(RST_STD), .RST_OD_CYC(RST_OD)) uut (
      .core_clk(core_clk), .reset(reset), .line_in(bus_line), .line_out(line_out),
      .line_oe(line_oe), .speed_select_pin(speed_select_pin), .act(act),
      .secret_locked(secret_locked), .area_locked(area_locked),
      .function_command(function_command), .secondary_command(secondary_command));

   swp_host_model host (.core_clk(core_clk), .line(bus_line), .host_low(host_low));

   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // gathers command pulses between two clears
   always @(posedge core_clk)
   begin
      if (clr_seen)
         seen <= '0;
      else if (|act[17:8])
      begin
         seen <= seen | act[17:8];
         seen_arg <= act.arg;
      end
   end

   function automatic logic [7:0] crc_ref(input logic [55:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 56; i++)
         c = (c >> 1) ^ (((c[0] ^ d[i]) == 1'b1) ? 8'h8C : 8'h00);
      return c;
   endfunction : crc_ref

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : check

   task automatic cmp_range(input int got, input int lo, input int hi, input string what);
      n_compared++;
      if (got < lo || got > hi)
      begin
         n_fail++;
         $display("mismatch at %0t: %s took %0d cycles", $time, what, got);
      end
   endtask : cmp_range

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic start(input logic [7:0] net);
      int tw;
      int tl;
      host.bus_reset(RST_OD + 30, tw, tl);
      host.send(net, 8);
   endtask : start

   task automatic mem_cmd(input logic [7:0] fn, input logic [15:0] a);
      host.send(fn, 8);
      host.send(a[7:0], 8);
      host.send(a[15:8], 8);
   endtask : mem_cmd

   // byte write; the model keeps only what the device must store
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      host.send(d, 8);
      if (a <= MEM_LAST && !lock_model[a[8:5]])
         mem_model[a] = d;
   endtask : wr

   initial
   begin
      repeat (125000) @(posedge core_clk);
      n_fail++;
      $display("mismatch at %0t: watchdog expired", $time);
      give_verdict();
   end

   initial
   begin
      logic [7:0]  d;
      logic        b0;
      logic        b1;
      logic [63:0] got;
      int          tw;
      int          tl;
      reset <= 1'b1;
      speed_select_pin <= 1'b0;
      clr_seen <= 1'b1;
      n_fail = 0;
      n_compared = 0;
      lock_model = 16'h0000;
      rnd = 32'hBA8D;
      exp_addr = {crc_ref({SERIAL_NUM, FAMILY_CODE}), SERIAL_NUM, FAMILY_CODE};
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      repeat (4) @(posedge core_clk);
      host.bus_reset(RST_STD + 200, tw, tl);
      cmp_range(tw, int'(STD_PDH_CYC), int'(STD_PDH_CYC) + 6, "std wait");
      cmp_range(tl, int'(STD_PDL_CYC) - 3, int'(STD_PDL_CYC) + 2, "std low");
      speed_select_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      host.bus_reset(RST_OD + 30, tw, tl);
      cmp_range(tw, int'(OD_PDH_CYC), int'(OD_PDH_CYC) + 6, "od wait");
      cmp_range(tl, int'(OD_PDL_CYC) - 3, int'(OD_PDL_CYC) + 2, "od low");
      host.send(NC_READ, 8);
      for (int i = 0; i < 64; i++)
      begin
         host.slot(1'b1, b0);
         got[i] = b0;
      end
      check(got, exp_addr, "net address");
      start(NC_SEARCH);
      for (int i = 0; i < 10; i++)
      begin
         host.slot(1'b1, b0);
         host.slot(1'b1, b1);
         if (i < 9)
            check({b0, b1}, {exp_addr[i], ~exp_addr[i]}, "search pair");
         else
            check({b0, b1}, 2'b11, "search loser");
         if (i < 9)
            host.send({7'h00, (i == 8) ? ~exp_addr[i] : exp_addr[i]}, 1);
      end
      start(NC_SKIP);
      mem_cmd(FN_WRITE, 16'h01FC);
      for (int k = 0; k < 5; k++)
      begin
         rnd = lfsr(rnd);
         wr(16'h01FC + 16'(k), rnd[7:0]);
      end
      start(NC_SKIP);
      mem_cmd(FN_WRITE, 16'h01FD);
      host.send(~mem_model[16'h01FD], 5);
      start(NC_MATCH);
      for (int k = 0; k < 8; k++)
         host.send(exp_addr[8*k +: 8], 8);
      mem_cmd(FN_READ, 16'h01FC);
      for (int k = 0; k < 4; k++)
      begin
         host.recv(d);
         check(d, mem_model[16'h01FC + 16'(k)], "read back");
      end
      start(NC_MATCH);
      for (int k = 0; k < 8; k++)
         host.send(exp_addr[8*k +: 8] ^ ((k == 0) ? 8'h01 : 8'h00), 8);
      mem_cmd(FN_READ, 16'h01FC);
      host.recv(d);
      check(d, 8'hFF, "unmatched read");
      for (int k = 0; k < 13; k++)
      begin
         clr_seen <= 1'b1;
         @(posedge core_clk);
         clr_seen <= 1'b0;
         start(NC_SKIP);
         mem_cmd(FN_WRITE, (k == 9) ? SEC_CMD_ADDR : FUNC_CMD_ADDR);
         wr((k == 9) ? SEC_CMD_ADDR : FUNC_CMD_ADDR, CODES[k][7:0]);
         wr((k == 9) ? SEC_CMD_ADDR + 16'h0001 : FUNC_CMD_ADDR + 16'h0001, CODES[k][15:8]);
         repeat (10) @(posedge core_clk);
         check(seen, MASKS[k], "command pulses");
         if (MASKS[k] != 10'h000)
            check(seen_arg, CODES[k][7:0], "command arg");
         if (k == 9)
            check(secondary_command, CODES[k], "secondary reg");
         else
            check(function_command, CODES[k], "command reg");
      end
      check(area_locked, 16'h8000, "area lock");
      check(secret_locked, 1'b1, "secret lock");
      lock_model[15] = 1'b1;
      start(NC_SKIP);
      mem_cmd(FN_WRITE, 16'h01FE);
      wr(16'h01FE, ~mem_model[16'h01FE]);
      start(NC_SKIP);
      mem_cmd(FN_READ, 16'h01FE);
      host.recv(d);
      check(d, mem_model[16'h01FE], "locked area");
      give_verdict();
   end
endmodule : tb_single_wire_slave_port
